/* core/couple_pkg.sv */
// Purpose: Shared constants and types of the channel coupling block
// Assumes: 32-bit APB register bus, one word per register
// Notes:   Point counts and skew picoseconds sit in the low bits
package couple_pkg;

    localparam int PW       = 24;
    localparam int DW       = 25;
    localparam int SW       = 13;
    localparam int SKEW_MAX_PS = 3000;

    localparam logic [7:0] A_SEL  = 8'h00;
    localparam logic [7:0] A_CPL  = 8'h04;
    localparam logic [7:0] A_COFF = 8'h08;
    localparam logic [7:0] A_SKEW = 8'h0c;
    localparam logic [7:0] A_ROLE = 8'h10;
    localparam logic [7:0] A_XOFF = 8'h14;
    localparam logic [7:0] A_XON  = 8'h18;
    localparam logic [7:0] A_LEN  = 8'h1c;
    localparam logic [7:0] A_RUN  = 8'h20;
    localparam logic [7:0] A_STAT = 8'h24;

    localparam logic [PW-1:0] LEN_RST   = 24'h000400;
    localparam logic [PW-1:0] MARGIN    = 24'h000080;
    localparam logic [PW-1:0] STEP_MASK = 24'hfffff8;

    localparam int ST_COARSE = 0;
    localparam int ST_SKEW   = 1;
    localparam int ST_XINST  = 2;
    localparam int ST_CABLE  = 3;
    localparam int ST_REFSEL = 4;

    typedef enum logic [1:0] {
        CH_ONE = 2'b01,
        CH_TWO = 2'b10
    } chan_t;

    typedef enum logic {
        ROLE_MASTER = 1'b0,
        ROLE_SLAVE  = 1'b1
    } role_t;

endpackage : couple_pkg

/* core/sync2.sv */
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t s_reg;
    sync_t s_next;

    always_comb begin
        s_next    = s_reg;
        s_next.s1 = d;
        s_next.s2 = s_reg.s1;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.s2;

endmodule : sync2

/* core/delay_counter.sv */
// Purpose: Delays a start pulse by a count of sample ticks
// Assumes: tick is a one-cycle enable on clk
// Notes:   A new start reloads the count and drops a pending one
`timescale 1ns/1ps
module delay_counter import couple_pkg::*; (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          tick,
    input  wire logic          start,
    input  wire logic [DW-1:0] delay,
    output logic               fire
);

    typedef struct packed {
        logic          busy;
        logic [DW-1:0] cnt;
        logic          fire;
    } dly_t;

    dly_t d_reg;
    dly_t d_next;

    always_comb begin
        d_next      = d_reg;
        d_next.fire = 1'b0;
        if (start) begin
            if (delay == '0) begin
                d_next.fire = 1'b1;
                d_next.busy = 1'b0;
            end else begin
                d_next.busy = 1'b1;
                d_next.cnt  = delay;
            end
        end else if (d_reg.busy && tick) begin
            d_next.cnt = d_reg.cnt - 1'b1;
            if (d_reg.cnt == {{(DW-1){1'b0}}, 1'b1}) begin
                d_next.busy = 1'b0;
                d_next.fire = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            d_reg <= '0;
        end else begin
            d_reg <= d_next;
        end
    end

    assign fire = d_reg.fire;

    chk_no_early_fire: assert property (@(posedge clk) disable iff (sys_rst)
        (start && delay != '0) ##1 (!start && !tick) |-> !fire)
        else $error("start fired before any tick");

endmodule : delay_counter

/* core/channel_phase_coupling.sv */
// Purpose: Channel and instrument coupling of a two-channel generator
// Assumes: Sample ticks are enables on clk; cable and ref pins are async
// Notes:   APB slave with zero wait states
//
// Functional notes
// - Selected channel takes later per-channel writes; query reports 1 or 2
// - Channel offset is points, zero to length minus 128, default zero
// - Channel offset takes effect in steps of 8 sample clocks
// - Lag between channels equals the difference of their offsets
// - Offset acts only in continuous mode with coupling and equal lengths
// - Second channel skew within plus or minus 3 ns, default zero
// - Skew always targets the second channel, whatever is selected
// - Coupling feeds channel two from channel one clock and start phase
// - Couple state query returns 1 when on and 0 when off
// - Role is master or slave, master by default; channel two follows only when coupled
// - Master role acts only with a cable present and instrument coupling on; slave role needs only the cable
// - Instrument offset zero to length, steps of 8, slave against master
// - Master drives the shared reference clock, slave runs from it
// - Coupled channels share run mode and the first channel sample clock
`timescale 1ns/1ps
module channel_phase_coupling import couple_pkg::*; (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          sclk1_tick,
    input  wire logic          sclk2_tick,
    input  wire logic          start1_req,
    input  wire logic          start2_req,
    input  wire logic          cable_present_n,
    input  wire logic          ref_in,
    output logic               ref_out,
    output logic               ref_oe_n,
    output logic               ch1_start,
    output logic               ch2_start,
    output logic               ch2_clk_from_ch1,
    output logic      [SW-1:0] ch2_skew_ps,
    output logic               ext_ref_sel
);

    typedef struct packed {
        chan_t         sel;
        logic          cpl;
        logic          cont;
        logic [PW-1:0] off1;
        logic [PW-1:0] off2;
        logic [PW-1:0] len1;
        logic [PW-1:0] len2;
        logic [PW-1:0] xoff;
        logic [SW-1:0] skew;
        logic [SW-1:0] skew_out;
        role_t         role;
        logic          xon;
        logic [31:0]   rdata;
        logic          err;
        logic          rprev;
        logic          refq;
        logic          oe_n;
        logic          rsel;
    } state_t;

    localparam state_t RST = '{sel: CH_ONE, role: ROLE_MASTER, len1: LEN_RST,
                               len2: LEN_RST, oe_n: 1'b1, default: '0};

    state_t        q_reg;
    state_t        q_next;
    logic [1:0]    pins;
    logic          cable;
    logic          ref_edge;
    logic          x_act;
    logic          slave_act;
    logic          master_act;
    logic          c_act;
    logic [PW-1:0] len_sel;
    logic [PW-1:0] diff;
    logic [DW-1:0] d1;
    logic [DW-1:0] d2;
    logic [DW-1:0] xd;
    logic [DW-1:0] dly1;
    logic [DW-1:0] dly2;
    logic          tick1;
    logic          tick2;
    logic          start2_src;
    logic          ok;

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs and coupling terms

    sync2 #(.W(2)) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       ({cable_present_n, ref_in}),
        .q       (pins)
    );

    assign cable      = ~pins[1];
    assign ref_edge   = pins[0] ^ q_reg.rprev;
    assign x_act      = q_reg.xon & cable;
    assign slave_act  = cable & (q_reg.role == ROLE_SLAVE);
    assign master_act = x_act & (q_reg.role == ROLE_MASTER);
    // Both coupled channels must run continuous with equal lengths
    assign c_act      = q_reg.cpl & q_reg.cont & (q_reg.len1 == q_reg.len2);
    assign len_sel    = (q_reg.sel == CH_TWO) ? q_reg.len2 : q_reg.len1;

    // The later channel is the one with the smaller offset
    assign diff = (q_reg.off1 >= q_reg.off2) ? q_reg.off1 - q_reg.off2
                                             : q_reg.off2 - q_reg.off1;
    assign d2 = (c_act && q_reg.off1 >= q_reg.off2) ?
                {1'b0, diff & STEP_MASK} : '0;
    assign d1 = (c_act && q_reg.off1 < q_reg.off2) ?
                {1'b0, diff & STEP_MASK} : '0;
    assign xd   = slave_act ? {1'b0, q_reg.xoff & STEP_MASK} : '0;
    assign dly1 = xd + d1;
    assign dly2 = xd + d2;

    // Slave counts edges of the master reference instead of its own clock
    assign tick1      = slave_act ? ref_edge : sclk1_tick;
    assign tick2      = q_reg.cpl ? tick1 : sclk2_tick;
    assign start2_src = q_reg.cpl ? start1_req : start2_req;

    ////////////////////////////////////////////////////////////////////////
    // Register file and coupling state

    always_comb begin
        q_next          = q_reg;
        ok              = 1'b1;
        q_next.rprev    = pins[0];
        q_next.skew_out = c_act ? q_reg.skew : '0;
        q_next.oe_n     = ~master_act;
        q_next.rsel     = slave_act;
        if (master_act && sclk1_tick) begin
            q_next.refq = ~q_reg.refq;
        end
        if (psel && !penable) begin
            q_next.rdata = '0;
            case (paddr)
                A_SEL: begin
                    q_next.rdata[1:0] = q_reg.sel;
                    ok = pwdata[1:0] == CH_ONE || pwdata[1:0] == CH_TWO;
                end
                A_CPL: q_next.rdata[0] = q_reg.cpl;
                A_COFF: begin
                    q_next.rdata[PW-1:0] = (q_reg.sel == CH_TWO) ? q_reg.off2
                                                                  : q_reg.off1;
                    ok = pwdata[31:PW] == '0 && len_sel >= MARGIN &&
                         pwdata[PW-1:0] <= len_sel - MARGIN;
                end
                A_SKEW: begin
                    q_next.rdata[SW-1:0] = q_reg.skew;
                    ok = $signed(pwdata) >= -SKEW_MAX_PS &&
                         $signed(pwdata) <= SKEW_MAX_PS;
                end
                A_ROLE: q_next.rdata[0] = q_reg.role;
                A_XOFF: begin
                    q_next.rdata[PW-1:0] = q_reg.xoff;
                    ok = pwdata[31:PW] == '0 && pwdata[PW-1:0] <= q_reg.len1 &&
                         (pwdata[PW-1:0] & ~STEP_MASK) == '0;
                end
                A_XON: q_next.rdata[0] = q_reg.xon;
                A_LEN: q_next.rdata[PW-1:0] = len_sel;
                A_RUN: q_next.rdata[0] = q_reg.cont;
                A_STAT: begin
                    q_next.rdata[ST_COARSE] = c_act;
                    q_next.rdata[ST_SKEW]   = q_reg.skew_out != '0;
                    q_next.rdata[ST_XINST]  = x_act;
                    q_next.rdata[ST_CABLE]  = cable;
                    q_next.rdata[ST_REFSEL] = q_reg.rsel;
                    ok = !pwrite;
                end
                default: ok = 1'b0;
            endcase
            q_next.err = !(ok || !pwrite) || !(paddr inside {A_SEL, A_CPL,
                         A_COFF, A_SKEW, A_ROLE, A_XOFF, A_XON, A_LEN, A_RUN,
                         A_STAT});
        end
        if (psel && penable && pwrite && !q_reg.err) begin
            case (paddr)
                A_SEL:  q_next.sel = chan_t'(pwdata[1:0]);
                A_CPL:  q_next.cpl = pwdata[0];
                A_COFF: begin
                    if (q_reg.sel == CH_TWO) begin
                        q_next.off2 = pwdata[PW-1:0];
                    end else begin
                        q_next.off1 = pwdata[PW-1:0];
                    end
                end
                A_SKEW: q_next.skew = pwdata[SW-1:0];
                A_ROLE: q_next.role = role_t'(pwdata[0]);
                A_XOFF: q_next.xoff = pwdata[PW-1:0];
                A_XON:  q_next.xon  = pwdata[0];
                A_LEN: begin
                    if (q_reg.sel == CH_TWO) begin
                        q_next.len2 = pwdata[PW-1:0];
                    end else begin
                        q_next.len1 = pwdata[PW-1:0];
                    end
                end
                A_RUN:  q_next.cont = pwdata[0];
                default: q_next.cont = q_reg.cont;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q_reg <= RST;
        end else begin
            q_reg <= q_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start delay per channel

    delay_counter u_dly1 (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick1),
        .start   (start1_req),
        .delay   (dly1),
        .fire    (ch1_start)
    );

    delay_counter u_dly2 (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick2),
        .start   (start2_src),
        .delay   (dly2),
        .fire    (ch2_start)
    );

    assign prdata           = q_reg.rdata;
    assign pslverr          = q_reg.err;
    assign pready           = 1'b1;
    assign ref_out          = q_reg.refq;
    assign ref_oe_n         = q_reg.oe_n;
    assign ch2_clk_from_ch1 = q_reg.cpl;
    assign ch2_skew_ps      = q_reg.skew_out;
    assign ext_ref_sel      = q_reg.rsel;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_sel_target: assert property (@(posedge clk) disable iff (sys_rst)
        (psel && penable && pwrite && paddr == A_COFF && !q_reg.err &&
         q_reg.sel == CH_TWO) |=> (q_reg.off2 == $past(pwdata[PW-1:0]) &&
         $stable(q_reg.off1)))
        else $error("offset write missed the selected channel");

    chk_coff_range: assert property (@(posedge clk) disable iff (sys_rst)
        (psel && !penable && pwrite && paddr == A_COFF &&
         pwdata[PW-1:0] > len_sel - MARGIN) |=> pslverr)
        else $error("offset beyond length minus margin accepted");

    chk_step_eight: assert property (@(posedge clk) disable iff (sys_rst)
        (dly1[2:0] == 3'h0) && (dly2[2:0] == 3'h0))
        else $error("start delay not a multiple of eight");

    chk_lag_diff: assert property (@(posedge clk) disable iff (sys_rst)
        (c_act && q_reg.off1 >= q_reg.off2) |->
        (dly2 - dly1 == {1'b0, (q_reg.off1 - q_reg.off2) & STEP_MASK}))
        else $error("lag differs from offset difference");

    chk_coarse_gate: assert property (@(posedge clk) disable iff (sys_rst)
        !c_act |-> (dly1 == dly2))
        else $error("channel offset applied while inactive");

    chk_skew_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !q_reg.cpl ##1 !q_reg.cpl |-> ch2_skew_ps == '0)
        else $error("skew applied with coupling off");

    chk_skew_any_sel: assert property (@(posedge clk) disable iff (sys_rst)
        (psel && penable && pwrite && paddr == A_SKEW && !q_reg.err) |=>
        q_reg.skew == $past(pwdata[SW-1:0]))
        else $error("skew write lost");

    chk_couple_tick: assert property (@(posedge clk) disable iff (sys_rst)
        q_reg.cpl |-> (tick2 == tick1 && start2_src == start1_req))
        else $error("coupled channel two not fed from channel one");

    chk_cpl_query: assert property (@(posedge clk) disable iff (sys_rst)
        (psel && !penable && !pwrite && paddr == A_CPL) |=>
        prdata == {31'h0, $past(q_reg.cpl)})
        else $error("couple query wrong");

    chk_role_gate: assert property (@(posedge clk) disable iff (sys_rst)
        !cable |=> (ref_oe_n && !ext_ref_sel))
        else $error("role acted without cable");

    chk_ref_drive: assert property (@(posedge clk) disable iff (sys_rst)
        (master_act && sclk1_tick) |=> ref_out != $past(ref_out))
        else $error("master did not advance reference clock");

endmodule : channel_phase_coupling

/* testbench/peer_instrument.sv */
// Purpose: Second instrument on the sync cable, as seen from the block
// Assumes: drive_ref set means this peer is the master instrument
// Notes:   An undriven reference line shows a random pattern, never a held value
`timescale 1ns/1ps
module peer_instrument (
    input  wire logic clk,
    input  wire logic attached,
    input  wire logic drive_ref,
    input  wire logic dut_ref_out,
    input  wire logic dut_ref_oe_n,
    output logic      cable_n,
    output logic      ref_line
);
    logic       phase;

    initial begin
        phase = 1'b0;
        ref_line = 1'b0;
    end

    assign cable_n = !attached;
    always @(posedge clk) begin
        phase <= !phase;
        // Only the enabled master drives the shared reference clock
        if (attached && drive_ref) begin
            if (phase) begin
                ref_line <= !ref_line;
            end
        end else if (attached && !dut_ref_oe_n) begin
            ref_line <= dut_ref_out;
        end else begin
            ref_line <= 1'($urandom);
        end
    end
endmodule : peer_instrument

/* testbench/test_channel_phase_coupling.sv */
// Purpose: Self-checking bench of the coupling block
// Assumes: Zero wait state APB, ticks and starts driven on rising edges
// Notes:   Offsets kept small so the run stays short
`timescale 1ns/1ps
`define CHK(g, e) cmp(32'(g), 32'(e))
module test_channel_phase_coupling;
    import couple_pkg::*;
    logic          clk, sys_rst, psel, penable, pwrite;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic          pready, pslverr, sclk1_tick, sclk2_tick, start1_req, start2_req;
    logic          cable_present_n, ref_in, ref_out, ref_oe_n, ch1_start, ch2_start;
    logic          ch2_clk_from_ch1, ext_ref_sel, attached, peer_master, r0;
    logic [SW-1:0] ch2_skew_ps;
    int            err_count, checked, cyc, o, k, s;

    channel_phase_coupling dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk1_tick(sclk1_tick),
        .sclk2_tick(sclk2_tick), .start1_req(start1_req), .start2_req(start2_req),
        .cable_present_n(cable_present_n), .ref_in(ref_in), .ref_out(ref_out),
        .ref_oe_n(ref_oe_n), .ch1_start(ch1_start), .ch2_start(ch2_start),
        .ch2_clk_from_ch1(ch2_clk_from_ch1), .ch2_skew_ps(ch2_skew_ps),
        .ext_ref_sel(ext_ref_sel));
    peer_instrument peer (.clk(clk), .attached(attached), .drive_ref(peer_master),
        .dut_ref_out(ref_out), .dut_ref_oe_n(ref_oe_n), .cable_n(cable_present_n),
        .ref_line(ref_in));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = !clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got %h expected %h", $time, g, e);
        end
    endtask : cmp

    task automatic test_done;
        $display("Counts: %0d checks, %0d mismatches", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            test_done;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Setup then access; hold everything until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge clk);
        end
        if (n == 16) err_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        `CHK(e, ee);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
        logic e;
        apb(1'b0, a, 32'h0, rd, e);
        `CHK(rd, ex);
    endtask : rdc

    // Both starts fire after their own tick counts from one shared request
    task automatic run_start(input int e1, input int e2);
        int c1, c2, cnt, n;
        c1 = -1;
        c2 = -1;
        cnt = 0;
        @(posedge clk);
        start1_req <= 1'b1;
        sclk1_tick <= 1'b0;
        @(posedge clk);
        start1_req <= 1'b0;
        sclk1_tick <= 1'($urandom);
        for (n = 0; n < 3000 && (c1 < 0 || c2 < 0); n++) begin
            @(posedge clk);
            if (ch1_start === 1'b1 && c1 < 0) c1 = cnt;
            if (ch2_start === 1'b1 && c2 < 0) c2 = cnt;
            cnt += int'(sclk1_tick);
            sclk1_tick <= 1'($urandom);
            sclk2_tick <= 1'($urandom);
        end
        // A tick left high would keep toggling the master reference later on
        sclk1_tick <= 1'b0;
        sclk2_tick <= 1'b0;
        `CHK(c1, e1);
        `CHK(c2, e2);
        $display("Test start delay %0d/%0d done", e1, e2);
    endtask : run_start
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {sclk1_tick, sclk2_tick, start1_req, start2_req, attached, peer_master} = '0;
        err_count = 0;
        checked = 0;
        cyc = 0;
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        void'($urandom(62150));
        `CHK({ch2_clk_from_ch1, ref_oe_n, ext_ref_sel, ch2_skew_ps}, 32'h4000);
        rdc(A_SEL, 1);
        rdc(A_CPL, 0);
        rdc(A_COFF, 0);
        rdc(A_SKEW, 0);
        rdc(A_ROLE, 0);
        rdc(A_XOFF, 0);
        rdc(A_XON, 0);
        rdc(A_LEN, 32'h400);
        wr(8'h40, 0, 1);
        wr(A_STAT, 0, 1);
        wr(A_SEL, 3, 1);
        wr(A_COFF, 32'h381, 1);
        wr(A_COFF, 32'h380, 0);
        wr(A_SEL, 2, 0);
        rdc(A_SEL, 2);
        rdc(A_COFF, 0);
        wr(A_SEL, 1, 0);
        rdc(A_COFF, 32'h380);
        $display("Test registers done");
        wr(A_CPL, 1, 0);
        rdc(A_CPL, 1);
        `CHK(ch2_clk_from_ch1, 1);
        wr(A_SKEW, -3000, 0);
        wr(A_SKEW, 3000, 0);
        s = int'($urandom % 6001) - 3000;
        wr(A_SKEW, s, 0);
        wr(A_SKEW, 3001, 1);
        wr(A_SKEW, -3001, 1);
        `CHK(ch2_skew_ps, 0);
        wr(A_RUN, 1, 0);
        wr(A_SEL, 2, 0);
        rdc(A_SKEW, 32'(s) & 32'h1fff);
        `CHK(ch2_skew_ps, 13'(s));
        $display("Test skew done");
        repeat (3) begin
            o = int'($urandom % 256);
            wr(A_COFF, 0, 0);
            wr(A_SEL, 1, 0);
            wr(A_COFF, o, 0);
            run_start(0, o & ~7);
            wr(A_COFF, 0, 0);
            wr(A_SEL, 2, 0);
            wr(A_COFF, o + 7, 0);
            run_start((o + 7) & ~7, 0);
        end
        wr(A_RUN, 0, 0);
        run_start(0, 0);
        `CHK(ch2_skew_ps, 0);
        wr(A_RUN, 1, 0);
        wr(A_LEN, 32'h200, 0);
        run_start(0, 0);
        wr(A_CPL, 0, 0);
        rdc(A_COFF, (o + 7));
        `CHK({ch2_clk_from_ch1, ch2_skew_ps}, 0);
        // Uncoupled, each channel answers its own start request only
        start1_req <= 1'b1;
        @(posedge clk);
        start1_req <= 1'b0;
        start2_req <= 1'b1;
        @(posedge clk);
        start2_req <= 1'b0;
        `CHK({ch1_start, ch2_start}, 2'b10);
        @(posedge clk);
        `CHK({ch1_start, ch2_start}, 2'b01);
        attached <= 1'b1;
        wr(A_XON, 1, 0);
        repeat (4) @(posedge clk);
        `CHK(ref_oe_n, 0);
        r0 = ref_out;
        k = int'($urandom % 9) + 1;
        for (int i = 0; i < k; i++) begin
            sclk1_tick <= 1'b1;
            @(posedge clk);
        end
        sclk1_tick <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(ref_out, r0 ^ k[0]);
        attached <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK({ref_oe_n, ext_ref_sel}, 2'b10);
        $display("Test master reference done");
        // The enable goes to the master only, so it is withdrawn before the role changes
        wr(A_XON, 0, 0);
        wr(A_ROLE, 1, 0);
        rdc(A_ROLE, 1);
        wr(A_XOFF, 12, 1);
        wr(A_XOFF, 32'h408, 1);
        wr(A_XOFF, 32'h400, 0);
        repeat (4) @(posedge clk);
        `CHK(ext_ref_sel, 0);
        peer_master <= 1'b1;
        attached <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK({ref_oe_n, ext_ref_sel}, 2'b11);
        // Peer toggles its reference every second cycle: 16 edges take about 32 cycles
        wr(A_XOFF, 16, 0);
        k = 0;
        start1_req <= 1'b1;
        @(posedge clk);
        start1_req <= 1'b0;
        while (ch1_start !== 1'b1 && k < 100) begin
            @(posedge clk);
            k++;
        end
        `CHK(k inside {[31:34]}, 1);
        $display("Test slave reference done");
        test_done;
    end
endmodule : test_channel_phase_coupling
